// file: cpce_pkg.sv
package cpce_pkg;

  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_SHUNT  = 8'h01;
  localparam logic [7:0] ADDR_BUS    = 8'h02;
  localparam logic [7:0] ADDR_POWER  = 8'h03;
  localparam logic [7:0] ADDR_CURR   = 8'h04;
  localparam logic [7:0] ADDR_SCALE  = 8'h05;

  localparam logic [15:0] CONFIG_RST = 16'h4127;
  localparam logic [15:0] SCALE_RST  = 16'h0000;
  localparam logic [15:0] ZERO16     = 16'h0000;

  localparam int CURR_SHIFT  = 11;
  localparam logic [31:0] POWER_DIV = 32'h0000_4E20;
  localparam int BUS_MSB     = 15;
  localparam int DIV_STEPS   = 32;

  localparam int AVG_POS     = 9;
  localparam int AVG_W       = 3;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CURR = 2'b01,
    ST_DIV  = 2'b10,
    ST_DONE = 2'b11
  } cpce_state_t;

endpackage

// file: cpce_divider.sv
`timescale 1ns/10ps
`default_nettype none
module cpce_divider
  import cpce_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  output logic             busy,
  output logic [31:0]      quotient
);
  import cpce_pkg::*;

  logic [31:0] quotQ;
  logic [31:0] quotD;
  logic [32:0] remQ;
  logic [32:0] remD;
  logic [5:0]  cntQ;
  logic [5:0]  cntD;
  logic [32:0] trial;

  // Restoring division, one quotient bit per clock; remainder is dropped.
  always_comb
  begin
    quotD = quotQ;
    remD  = remQ;
    cntD  = cntQ;
    trial = 33'h0_0000_0000;
    if (start)
    begin
      quotD = dividend;
      remD  = 33'h0_0000_0000;
      cntD  = 6'(DIV_STEPS);
    end
    else if (cntQ != 6'h00)
    begin
      trial = {remQ[31:0], quotQ[31]};
      quotD = {quotQ[30:0], 1'b0};
      if (trial >= {1'b0, divisor})
      begin
        remD     = trial - {1'b0, divisor};
        quotD[0] = 1'b1;
      end
      else
      begin
        remD = trial;
      end
      cntD = cntQ - 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quotQ <= 32'h0000_0000;
      remQ  <= 33'h0_0000_0000;
      cntQ  <= 6'h00;
    end
    else
    begin
      quotQ <= quotD;
      remQ  <= remD;
      cntQ  <= cntD;
    end
  end

  assign busy     = (cntQ != 6'h00);
  assign quotient = quotQ;
endmodule
`default_nettype wire

// file: current_power_calc_engine.sv
`timescale 1ns/10ps
`default_nettype none
module current_power_calc_engine
  import cpce_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        sampleValid,
  input  wire logic [15:0] shuntSample,
  input  wire logic [15:0] busSample,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  output logic [15:0]      regRdata,
  output logic             continuousMode,
  output logic             sampleReady
);
  import cpce_pkg::*;

  cpce_state_t stateQ;
  cpce_state_t stateD;

  logic [15:0] configQ;
  logic [15:0] configD;
  logic [15:0] scaleQ;
  logic [15:0] scaleD;
  logic        scaleSetQ;
  logic        scaleSetD;
  logic [15:0] shuntRegQ;
  logic [15:0] shuntRegD;
  logic [15:0] busRegQ;
  logic [15:0] busRegD;
  logic [15:0] currRegQ;
  logic [15:0] currRegD;
  logic [15:0] powerRegQ;
  logic [15:0] powerRegD;
  logic [15:0] curSampQ;
  logic [15:0] curSampD;
  logic [15:0] busSampQ;
  logic [15:0] busSampD;
  logic [15:0] shSampQ;
  logic [15:0] shSampD;
  // Forty-eight bit accumulators hold a full set of 1024 sums with
  // headroom, so the final shift needs no saturation.
  logic [47:0] accShQ;
  logic [47:0] accShD;
  logic [47:0] accBusQ;
  logic [47:0] accBusD;
  logic [47:0] accCurQ;
  logic [47:0] accCurD;
  logic [47:0] accPowQ;
  logic [47:0] accPowD;
  logic [10:0] avgCntQ;
  logic [10:0] avgCntD;
  logic [15:0] rdataQ;
  logic [15:0] rdataD;
  logic        modeQ;
  logic        modeD;

  logic [31:0] prodCurr;
  logic [31:0] prodPow;
  logic [15:0] currNow;
  logic [15:0] currSel;
  logic [15:0] currMag;
  logic [10:0] avgTarget;
  logic [3:0]  avgShift;
  logic        divStart;
  logic        divBusy;
  logic [31:0] divQuot;

  // Averaging count from the configuration field: 1,4,16,64,128,256,512,1024.
  always_comb
  begin
    case (configQ[AVG_POS +: AVG_W])
      3'd0:    avgShift = 4'd0;
      3'd1:    avgShift = 4'd2;
      3'd2:    avgShift = 4'd4;
      3'd3:    avgShift = 4'd6;
      3'd4:    avgShift = 4'd7;
      3'd5:    avgShift = 4'd8;
      3'd6:    avgShift = 4'd9;
      default: avgShift = 4'd10;
    endcase
    avgTarget = 11'((12'h001 << avgShift) - 12'h001);
  end

  // Signed shunt times scale; arithmetic shift would floor, so negative
  // products are offset to truncate toward zero instead.
  assign prodCurr = 32'($signed(shSampQ) * $signed({1'b0, scaleQ}));
  always_comb
  begin
    if (prodCurr[31])
    begin
      currNow = 16'(($signed(prodCurr) + 32'sd2047) >>> CURR_SHIFT);
    end
    else
    begin
      currNow = 16'(prodCurr >> CURR_SHIFT);
    end
  end

  // Power is built from the current being stored in this very state, not
  // from the previous sample's register; bus is always positive.
  assign currSel  = scaleSetQ ? currNow : ZERO16;
  assign currMag  = currSel[15] ? 16'(~currSel + 16'h0001) : currSel;
  assign prodPow  = 32'(currMag) * 32'(busSampQ);
  // Division by 20000 takes 32 clocks; samples are refused meanwhile,
  // which is far shorter than any conversion the converter delivers.
  assign divStart = (stateQ == ST_CURR);

  cpce_divider u_div
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .start    (divStart),
    .dividend (prodPow),
    .divisor  (POWER_DIV),
    .busy     (divBusy),
    .quotient (divQuot)
  );

  always_comb
  begin
    stateD    = stateQ;
    configD   = configQ;
    scaleD    = scaleQ;
    scaleSetD = scaleSetQ;
    shuntRegD = shuntRegQ;
    busRegD   = busRegQ;
    currRegD  = currRegQ;
    powerRegD = powerRegQ;
    curSampD  = curSampQ;
    busSampD  = busSampQ;
    shSampD   = shSampQ;
    accShD    = accShQ;
    accBusD   = accBusQ;
    accCurD   = accCurQ;
    accPowD   = accPowQ;
    avgCntD   = avgCntQ;
    // The flag, not the word's value, gates the results, because a scale
    // written as zero still counts as programmed.
    if (regWrite && regAddr == ADDR_SCALE)
    begin
      scaleD    = regWdata;
      scaleSetD = 1'b1;
    end
    case (stateQ)
      ST_IDLE:
      begin
        if (sampleValid)
        begin
          shSampD  = shuntSample;
          busSampD = {1'b0, busSample[BUS_MSB-1:0]};
          stateD   = ST_CURR;
        end
      end
      ST_CURR:
      begin
        curSampD = currSel;
        stateD   = ST_DIV;
      end
      ST_DIV:
      begin
        if (!divBusy && !divStart)
        begin
          stateD = ST_DONE;
        end
      end
      ST_DONE:
      begin
        accShD  = accShQ + 48'($signed(shSampQ));
        accBusD = accBusQ + 48'(busSampQ);
        accCurD = accCurQ + 48'($signed(curSampQ));
        accPowD = accPowQ + 48'(divQuot[15:0]);
        if (avgCntQ == avgTarget)
        begin
          shuntRegD = 16'($signed(accShD) >>> avgShift);
          busRegD   = 16'(accBusD >> avgShift);
          currRegD  = scaleSetQ ? 16'($signed(accCurD) >>> avgShift)
                                : ZERO16;
          powerRegD = scaleSetQ ? 16'(accPowD >> avgShift)
                                : ZERO16;
          avgCntD   = 11'h000;
          accShD    = 48'h0000_0000_0000;
          accBusD   = 48'h0000_0000_0000;
          accCurD   = 48'h0000_0000_0000;
          accPowD   = 48'h0000_0000_0000;
        end
        else
        begin
          avgCntD = avgCntQ + 11'h001;
        end
        stateD = ST_IDLE;
      end
      default:
      begin
        stateD = ST_IDLE;
      end
    endcase
    // A configuration write comes after the sequencer so that it wins over
    // a sample folded in at the same edge; the new set always starts empty.
    if (regWrite && regAddr == ADDR_CONFIG)
    begin
      configD = regWdata;
      avgCntD = 11'h000;
      accShD  = 48'h0000_0000_0000;
      accBusD = 48'h0000_0000_0000;
      accCurD = 48'h0000_0000_0000;
      accPowD = 48'h0000_0000_0000;
    end
    // Mode bits 2:0 = 3'b111 means continuous shunt and bus conversion.
    modeD = (configD[2:0] == 3'b111);
  end

  // Register read mux; unmapped addresses read as zero rather than
  // repeating the last word, so a stray pointer is easy to spot.
  always_comb
  begin
    rdataD = rdataQ;
    if (regRead)
    begin
      case (regAddr)
        ADDR_CONFIG: rdataD = configQ;
        ADDR_SHUNT:  rdataD = shuntRegQ;
        ADDR_BUS:    rdataD = busRegQ;
        ADDR_POWER:  rdataD = powerRegQ;
        ADDR_CURR:   rdataD = currRegQ;
        ADDR_SCALE:  rdataD = scaleQ;
        default:     rdataD = ZERO16;
      endcase
    end
  end

  // All state returns to defaults on every reset; nothing is retained.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateQ    <= ST_IDLE;
      configQ   <= CONFIG_RST;
      scaleQ    <= SCALE_RST;
      scaleSetQ <= 1'b0;
      shuntRegQ <= ZERO16;
      busRegQ   <= ZERO16;
      currRegQ  <= ZERO16;
      powerRegQ <= ZERO16;
      curSampQ  <= ZERO16;
      busSampQ  <= ZERO16;
      shSampQ   <= ZERO16;
      accShQ    <= 48'h0000_0000_0000;
      accBusQ   <= 48'h0000_0000_0000;
      accCurQ   <= 48'h0000_0000_0000;
      accPowQ   <= 48'h0000_0000_0000;
      avgCntQ   <= 11'h000;
      rdataQ    <= ZERO16;
      modeQ     <= (CONFIG_RST[2:0] == 3'b111);
    end
    else
    begin
      stateQ    <= stateD;
      configQ   <= configD;
      scaleQ    <= scaleD;
      scaleSetQ <= scaleSetD;
      shuntRegQ <= shuntRegD;
      busRegQ   <= busRegD;
      currRegQ  <= currRegD;
      powerRegQ <= powerRegD;
      curSampQ  <= curSampD;
      busSampQ  <= busSampD;
      shSampQ   <= shSampD;
      accShQ    <= accShD;
      accBusQ   <= accBusD;
      accCurQ   <= accCurD;
      accPowQ   <= accPowD;
      avgCntQ   <= avgCntD;
      rdataQ    <= rdataD;
      modeQ     <= modeD;
    end
  end

  // The mode flag leaves a flop, loaded at the same edge as the configuration register,
  // so the pin never glitches while the register bus is busy.
  assign continuousMode = modeQ;
  assign sampleReady    = (stateQ == ST_IDLE);
  assign regRdata       = rdataQ;
endmodule
`default_nettype wire

// file: cpce_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cpce_assertions
  import cpce_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        sampleValid,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        continuousMode,
  input wire logic        sampleReady
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    sampleValid && sampleReady;
  endsequence
  // A write followed at once by a read must return the written word.
  sequence s_wr_rd(a);
    regWrite && regAddr == a ##1 regRead && regAddr == a;
  endsequence
  property p_back(a);
    s_wr_rd(a) |=> regRdata == $past(regWdata, 2);
  endproperty
  a_busy_take: assert property (s_take |=> !sampleReady [*8])
    else $error("Ready stayed high.");
  a_ready_back: assert property (s_take |-> ##[30:40] sampleReady)
    else $error("Ready never returned.");
  a_read_unmap: assert property (regRead && regAddr > ADDR_SCALE
    |=> regRdata == ZERO16) else $error("Unmapped read not zero.");
  a_read_hold: assert property (!regRead |=> $stable(regRdata))
    else $error("Read data moved.");
  a_bus_msb: assert property (regRead && regAddr == ADDR_BUS
    |=> !regRdata[BUS_MSB]) else $error("Bus top bit set.");
  a_cfg_back: assert property (p_back(ADDR_CONFIG))
    else $error("Config readback wrong.");
  a_cal_back: assert property (p_back(ADDR_SCALE))
    else $error("Scale readback wrong.");
  a_mode_follow: assert property (regWrite && regAddr == ADDR_CONFIG
    |=> continuousMode == (($past(regWdata) & 16'h0007) == 16'h0007))
    else $error("Mode flag wrong.");
endmodule
bind current_power_calc_engine cpce_assertions u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .sampleValid(sampleValid),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata),
  .continuousMode(continuousMode), .sampleReady(sampleReady));
`default_nettype wire

// file: tb_current_power_calc_engine.sv
`timescale 1ns/10ps
`default_nettype none
module tb_current_power_calc_engine;
  import cpce_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sampleValid = 1'b0;
  logic [15:0] shuntSample = 16'h0000;
  logic [15:0] busSample = 16'h0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata;
  logic        continuousMode;
  logic        sampleReady;
  logic [31:0] seed = 32'h0000_1D16;
  logic [15:0] rd;
  logic [15:0] cur;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  int          sum = 0;
  current_power_calc_engine uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .sampleValid(sampleValid),
    .shuntSample(shuntSample), .busSample(busSample),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata),
    .continuousMode(continuousMode), .sampleReady(sampleReady));
  initial
    forever #20 ref_clk = ~ref_clk;
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [15:0] cOf(logic [15:0] s, logic [15:0] k);
    int p;
    p = $signed(s) * $signed({16'h0000, k}) / 32'sh0000_0800;
    return p[15:0];
  endfunction
  function automatic logic [15:0] pOf(logic [15:0] c, logic [15:0] b);
    int a;
    a = $signed(c);
    a = (a < 0 ? -a : a) * b / 32'h0000_4E20;
    return a[15:0];
  endfunction
  // Strobes stay up after the edge so no signal is driven twice at once.
  task automatic acc(logic w, logic [7:0] a, logic [15:0] d);
    {regWrite, regRead, regAddr, regWdata} = {w, ~w, a, d};
    @(posedge ref_clk) #1 rd = regRdata;
  endtask
  task automatic cmp(logic [15:0] g, logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk(logic [7:0] a, logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    cmp(rd, e);
  endtask
  task automatic smp(logic [15:0] s, logic [15:0] b);
    {regWrite, regRead, sampleValid} = 3'h1;
    {shuntSample, busSample} = {s, b};
    @(posedge ref_clk) #1 sampleValid = 1'b0;
    for (int n = 0; n < 99 && sampleReady !== 1'b1; n++)
      @(posedge ref_clk) #1;
  endtask
  task automatic run(logic [15:0] s, logic [15:0] b, logic [15:0] k);
    acc(1'b1, ADDR_SCALE, k);
    chk(ADDR_SCALE, k);
    smp(s, b);
    cur = cOf(s, k);
    chk(ADDR_CURR, cur);
    chk(ADDR_POWER, pOf(cur, b & 16'h7FFF));
    chk(ADDR_BUS, b & 16'h7FFF);
  endtask
  task automatic end_sim();
    $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk)
    if (++cycles == 10000)
    begin
      miscompares++;
      end_sim();
    end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    cmp({15'h0000, continuousMode}, 16'h0001);
    chk(ADDR_CONFIG, 16'h4127);
    chk(ADDR_SCALE, 16'h0000);
    smp(16'h1F40, 16'h2570);
    chk(ADDR_SHUNT, 16'h1F40);
    chk(ADDR_CURR, 16'h0000);
    chk(ADDR_POWER, 16'h0000);
    $display("Test defaults done");
    run(16'h1F40, 16'h2570, 16'h0A00);
    chk(ADDR_POWER, 16'h12B8);
    acc(1'b1, ADDR_CURR, 16'hFFFF);
    chk(ADDR_CURR, 16'h2710);
    chk(8'h06, 16'h0000);
    run(16'h1F40, 16'h2570, 16'(32'd2560 * 32'd10100 / 32'(cur)));
    chk(ADDR_CURR, 16'h2771);
    run(16'h8000, 16'hFFFF, 16'h07FF);
    run(16'hFFFF, 16'h7FFF, 16'h0001);
    repeat (30)
      run(xs(), xs(), xs() & 16'h07FF);
    $display("Test scaling done");
    acc(1'b1, ADDR_SCALE, 16'h0A00);
    acc(1'b1, ADDR_CONFIG, 16'h4327);
    chk(ADDR_CONFIG, 16'h4327);
    for (int i = 0; i < 4; i++)
    begin
      chk(ADDR_CURR, cur);
      smp(16'h1F40 + i[15:0], 16'h2570);
      sum += cOf(16'h1F40 + i[15:0], 16'h0A00);
    end
    sum = sum >>> 2;
    chk(ADDR_CURR, sum[15:0]);
    $display("Test averaging done");
    acc(1'b1, ADDR_CONFIG, 16'h4120);
    cmp({15'h0000, continuousMode}, 16'h0000);
    {regWrite, regRead, rst_n} = 3'b000;
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    cmp({15'h0000, continuousMode}, 16'h0001);
    chk(ADDR_CONFIG, 16'h4127);
    chk(ADDR_SCALE, 16'h0000);
    chk(ADDR_CURR, 16'h0000);
    smp(16'h1F40, 16'h2570);
    chk(ADDR_CURR, 16'h0000);
    chk(ADDR_BUS, 16'h2570);
    $display("Test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
